// >>> host_attach_consts.svh
// Constants for the host attachment block.
`ifndef HOST_ATTACH_CONSTS_SVH
`define HOST_ATTACH_CONSTS_SVH
`define FUNC_LOAD_CTRL      3'h6
`define PAT_DISABLE         2'h0
`define PAT_CLEAR_UNIT      2'h1
`define PAT_ENABLE          2'h2
`define PAT_CLEAR_SUBSYS    2'h3
`define CTRL_LO_BIT         3
`define UNIT_COUNT          4
`define SRC_SUBSYS          2'h0
`define SRC_ADDRESS         2'h1
`define SRC_ATTACH          2'h2
`define SRC_HARDWARE        2'h3
`define ZERO_BYTE           8'h00
`endif

// >>> host_attach_pkg.sv
// Types for the host attachment block.
package host_attach_pkg;
	typedef enum logic [2:0] {
		CMD_LOAD  = 3'b000,
		CMD_START = 3'b001,
		CMD_SENSE = 3'b010,
		CMD_OPEND = 3'b011,
		CMD_BAD   = 3'b111
	} cmd_type;

	typedef struct packed {
		cmd_type     command;
		logic [2:0]  func;
		logic [7:0]  select;
		logic        readNotWrite;
	} cmd_word_type;

	typedef struct packed {
		logic [7:0] data;
		logic       parity;
	} pbyte_type;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_LOADB1 = 3'b001,
		ST_LOADB2 = 3'b010,
		ST_SENSE1 = 3'b011,
		ST_SENSE2 = 3'b100,
		ST_XFER   = 3'b101
	} state_type;
endpackage

// >>> host_attachment_io_control.sv
// Host attachment between a processor I/O channel and a tape subsystem.
// What this block does
// - Function 110 load takes two bytes, uses first.
// - Completion latch set at phase five of select.
// - Bits 3,4 pattern 00 disables, 10 enables.
// - Pattern 01 clears the selected unit's request.
// - Pattern 11 clears the subsystem request.
// - Parity of the control byte is checked.
// - Bad parity ends operation, sets processor check.
// - Command 111, or a load with function other than 110, sets processor check and flag.
// - Read or write requests a steal per byte.
// - The modifier byte is ignored for transfers.
// - Select byte picks the sense byte source.
// - Both sense bytes go to the processor.
// - Completion sense sends zero byte, then status.
// - Two inbound tags or wrong tag raise check.
`timescale 1ns/1ps
`default_nettype none
`include "host_attach_consts.svh"
module host_attachment_io_control (
	input  wire logic                         clock,
	input  wire logic                         nrst,
	input  wire logic                         commandValid,
	input  wire host_attach_pkg::cmd_word_type commandWord,
	input  wire logic                         clockPhaseFive,
	input  wire logic                         outByteValid,
	input  wire host_attach_pkg::pbyte_type   outByte,
	input  wire logic [3:0]                   unitIrqSet,
	input  wire logic                         subsysIrqSet,
	input  wire logic [7:0]                   subsysSenseByte,
	input  wire logic [7:0]                   addressRegByte,
	input  wire logic [7:0]                   hardwareSenseByte,
	input  wire logic [7:0]                   opEndStatus,
	input  wire logic [3:0]                   inboundTags,
	input  wire logic [3:0]                   expectedTag,
	input  wire logic                         tapeDataValid,
	input  wire logic [7:0]                   tapeData,
	output logic                              tapeDataReady,
	input  wire logic                         stealGrant,
	input  wire logic                         hostReady,
	output logic                              stealRequest,
	output logic                              inByteValid,
	output logic [7:0]                        inByte,
	output logic                              completionLatch,
	output logic                              irqEnable,
	output logic [3:0]                        unitIrqPending,
	output logic                              subsysIrqPending,
	output logic                              processorCheck,
	output logic                              channelOutputParityFlag,
	output logic                              invalidCommandFlag,
	output logic                              ioCheck,
	output logic                              hostIrq
);
	host_attach_pkg::state_type state_reg;
	host_attach_pkg::cmd_word_type cmd_reg;
	logic [7:0] bufData_reg [2];
	logic       bufValid_reg [2];
	logic       bufHead_reg;
	logic       bufTail_reg;
	logic       bufFull;
	logic       bufEmpty;
	logic       bufPush;
	logic       bufPop;
	logic [2:0] phaseSync_reg;
	logic       phaseLevel_reg;
	logic       phaseEdge;
	logic [7:0] senseFirst;
	logic [1:0] ctrlPat;
	logic       parityOk;
	logic       badTags;

	function automatic logic [7:0] pick_sense(input logic [1:0] src, input logic [7:0] s0, input logic [7:0] s1,
		input logic [7:0] s2, input logic [7:0] s3);
		case (src)
			`SRC_SUBSYS:  pick_sense = s0;
			`SRC_ADDRESS: pick_sense = s1;
			`SRC_ATTACH:  pick_sense = s2;
			default:      pick_sense = s3;
		endcase
	endfunction

	// Phase five arrives from the processor clock, so it is synchronised.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			phaseSync_reg  <= 3'h0;
			phaseLevel_reg <= 1'b0;
		end else begin
			phaseSync_reg  <= {phaseSync_reg[1:0], clockPhaseFive};
			phaseLevel_reg <= (phaseSync_reg[1] == phaseSync_reg[2]) ? phaseSync_reg[2] : phaseLevel_reg;
		end
	end
	assign phaseEdge = phaseSync_reg[1] & phaseSync_reg[2] & ~phaseLevel_reg;

	assign ctrlPat  = outByte.data[`CTRL_LO_BIT +: 2];
	assign parityOk = ^{outByte.data, outByte.parity};
	assign badTags  = ($countones(inboundTags) > 1) ||
		(inboundTags != 4'h0 && expectedTag != 4'h0 && inboundTags != expectedTag);

	assign bufFull  = bufValid_reg[0] & bufValid_reg[1];
	assign bufEmpty = ~bufValid_reg[bufHead_reg];
	assign bufPush  = tapeDataValid & tapeDataReady;
	assign bufPop   = (state_reg == host_attach_pkg::ST_XFER) & stealGrant & ~bufEmpty & hostReady;

	// Two-entry buffer on the read data path.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bufValid_reg[0] <= 1'b0;
			bufValid_reg[1] <= 1'b0;
			bufData_reg[0]  <= 8'h00;
			bufData_reg[1]  <= 8'h00;
			bufHead_reg     <= 1'b0;
			bufTail_reg     <= 1'b0;
			tapeDataReady   <= 1'b0;
		end else begin
			if (bufPush) begin
				bufData_reg[bufTail_reg]  <= tapeData;
				bufValid_reg[bufTail_reg] <= 1'b1;
				bufTail_reg               <= ~bufTail_reg;
			end
			if (bufPop) begin
				bufValid_reg[bufHead_reg] <= 1'b0;
				bufHead_reg               <= ~bufHead_reg;
			end
			tapeDataReady <= ~bufFull & ~(bufPush & (bufValid_reg[0] | bufValid_reg[1]) & ~bufPop);
		end
	end

	// Command sequencing and byte exchange with the processor.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_reg       <= host_attach_pkg::ST_IDLE;
			cmd_reg         <= '0;
			stealRequest    <= 1'b0;
			inByteValid     <= 1'b0;
			inByte          <= 8'h00;
			completionLatch <= 1'b0;
		end else begin
			inByteValid <= 1'b0;
			case (state_reg)
				host_attach_pkg::ST_IDLE: begin
					stealRequest <= 1'b0;
					if (commandValid) begin
						cmd_reg         <= commandWord;
						completionLatch <= 1'b0;
						case (commandWord.command)
							host_attach_pkg::CMD_LOAD: begin
								if (commandWord.func == `FUNC_LOAD_CTRL) begin
									state_reg <= host_attach_pkg::ST_LOADB1;
								end
							end
							host_attach_pkg::CMD_START: begin
								state_reg    <= host_attach_pkg::ST_XFER;
								stealRequest <= 1'b1;
							end
							host_attach_pkg::CMD_SENSE: begin
								state_reg <= host_attach_pkg::ST_SENSE1;
							end
							host_attach_pkg::CMD_OPEND: begin
								state_reg <= host_attach_pkg::ST_SENSE1;
							end
							default: begin
								state_reg <= host_attach_pkg::ST_IDLE;
							end
						endcase
					end
				end
				host_attach_pkg::ST_LOADB1: begin
					if (phaseEdge) begin
						completionLatch <= 1'b1;
					end
					if (outByteValid) begin
						state_reg <= parityOk ? host_attach_pkg::ST_LOADB2 : host_attach_pkg::ST_IDLE;
					end
				end
				host_attach_pkg::ST_LOADB2: begin
					if (outByteValid) begin
						state_reg <= host_attach_pkg::ST_IDLE;
					end
				end
				host_attach_pkg::ST_SENSE1: begin
					if (hostReady) begin
						inByteValid <= 1'b1;
						inByte      <= senseFirst;
						state_reg   <= host_attach_pkg::ST_SENSE2;
					end
				end
				host_attach_pkg::ST_SENSE2: begin
					if (hostReady) begin
						inByteValid <= 1'b1;
						inByte      <= (cmd_reg.command == host_attach_pkg::CMD_OPEND) ? opEndStatus :
							pick_sense(cmd_reg.select[1:0], subsysSenseByte, addressRegByte,
								{irqEnable, subsysIrqPending, unitIrqPending, ioCheck, processorCheck},
								hardwareSenseByte);
						state_reg   <= host_attach_pkg::ST_IDLE;
					end
				end
				host_attach_pkg::ST_XFER: begin
					if (bufPop) begin
						inByteValid <= cmd_reg.readNotWrite;
						inByte      <= bufData_reg[bufHead_reg];
					end
					if (commandValid || processorCheck || ioCheck) begin
						stealRequest <= 1'b0;
						state_reg    <= host_attach_pkg::ST_IDLE;
					end else begin
						stealRequest <= ~cmd_reg.readNotWrite | ~bufEmpty;
					end
				end
				default: begin
					state_reg <= host_attach_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign senseFirst = (cmd_reg.command == host_attach_pkg::CMD_OPEND) ? `ZERO_BYTE :
		pick_sense(cmd_reg.select[1:0], subsysSenseByte, addressRegByte,
			{irqEnable, subsysIrqPending, unitIrqPending, ioCheck, processorCheck}, hardwareSenseByte);

	// Interrupt control from the first load byte.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irqEnable        <= 1'b0;
			unitIrqPending   <= 4'h0;
			subsysIrqPending <= 1'b0;
			hostIrq          <= 1'b0;
		end else begin
			hostIrq <= irqEnable & (subsysIrqPending | (|unitIrqPending));
			if (state_reg == host_attach_pkg::ST_LOADB1 && outByteValid && parityOk && ctrlPat == `PAT_DISABLE) begin
				irqEnable <= 1'b0;
			end else if (state_reg == host_attach_pkg::ST_LOADB1 && outByteValid && parityOk &&
				ctrlPat == `PAT_ENABLE) begin
				irqEnable <= 1'b1;
			end
			for (int i = 0; i < `UNIT_COUNT; i++) begin
				if (unitIrqSet[i]) begin
					unitIrqPending[i] <= 1'b1;
				end else if (state_reg == host_attach_pkg::ST_LOADB1 && outByteValid && parityOk &&
					ctrlPat == `PAT_CLEAR_UNIT && cmd_reg.select[`CTRL_LO_BIT +: 2] == 2'(i)) begin
					unitIrqPending[i] <= 1'b0;
				end
			end
			if (subsysIrqSet) begin
				subsysIrqPending <= 1'b1;
			end else if (state_reg == host_attach_pkg::ST_LOADB1 && outByteValid && parityOk &&
				ctrlPat == `PAT_CLEAR_SUBSYS) begin
				subsysIrqPending <= 1'b0;
			end
		end
	end

	// Error flags; a new command other than an invalid one clears them, and any new command clears ioCheck unless a tag error comes in the same cycle.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			processorCheck          <= 1'b0;
			channelOutputParityFlag <= 1'b0;
			invalidCommandFlag      <= 1'b0;
			ioCheck                 <= 1'b0;
		end else begin
			if (outByteValid && !parityOk &&
				(state_reg == host_attach_pkg::ST_LOADB1 || state_reg == host_attach_pkg::ST_LOADB2)) begin
				processorCheck          <= 1'b1;
				channelOutputParityFlag <= 1'b1;
			end else if (state_reg == host_attach_pkg::ST_IDLE && commandValid &&
				(commandWord.command == host_attach_pkg::CMD_BAD ||
				(commandWord.command == host_attach_pkg::CMD_LOAD && commandWord.func != `FUNC_LOAD_CTRL))) begin
				processorCheck     <= 1'b1;
				invalidCommandFlag <= 1'b1;
			end else if (state_reg == host_attach_pkg::ST_IDLE && commandValid) begin
				processorCheck          <= 1'b0;
				channelOutputParityFlag <= 1'b0;
				invalidCommandFlag      <= 1'b0;
			end
			if (badTags) begin
				ioCheck <= 1'b1;
			end else if (state_reg == host_attach_pkg::ST_IDLE && commandValid) begin
				ioCheck <= 1'b0;
			end
		end
	end

	load_done_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_reg == host_attach_pkg::ST_LOADB1 && phaseEdge) |=> completionLatch)
		else $error("Completion latch not set at phase five.");
	irq_enable_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_reg == host_attach_pkg::ST_LOADB1 && outByteValid && parityOk && ctrlPat == `PAT_ENABLE)
		|=> irqEnable)
		else $error("Enable pattern did not set enable.");
	irq_disable_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_reg == host_attach_pkg::ST_LOADB1 && outByteValid && parityOk && ctrlPat == `PAT_DISABLE)
		|=> !irqEnable)
		else $error("Disable pattern did not clear enable.");
	subsys_clear_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_reg == host_attach_pkg::ST_LOADB1 && outByteValid && parityOk &&
		ctrlPat == `PAT_CLEAR_SUBSYS && !subsysIrqSet) |=> !subsysIrqPending)
		else $error("Subsystem request not cleared.");
	parity_end_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_reg == host_attach_pkg::ST_LOADB1 && outByteValid && !parityOk)
		|=> processorCheck && channelOutputParityFlag && state_reg == host_attach_pkg::ST_IDLE)
		else $error("Parity error not reported.");
	bad_command_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_reg == host_attach_pkg::ST_IDLE && commandValid &&
		commandWord.command == host_attach_pkg::CMD_BAD) |=> processorCheck && invalidCommandFlag)
		else $error("Invalid command not reported.");
	opend_zero_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_reg == host_attach_pkg::ST_SENSE1 && hostReady && cmd_reg.command == host_attach_pkg::CMD_OPEND)
		|=> inByteValid && inByte == 8'h00)
		else $error("Completion sense first byte not zero.");
	tag_check_a: assert property (@(posedge clock) disable iff (!nrst)
		($countones(inboundTags) > 1) |=> ioCheck)
		else $error("Tag conflict not flagged.");
	steal_ask_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_reg == host_attach_pkg::ST_IDLE && commandValid &&
		commandWord.command == host_attach_pkg::CMD_START) |=> stealRequest)
		else $error("No steal request after start.");
endmodule
`default_nettype wire

// >>> host_channel_model.sv
// Behavioural host channel that grants cycle steals and stores incoming bytes.
`timescale 1ns/1ps
`default_nettype none
module host_channel_model (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       stall,
	input  wire logic       stealRequest,
	input  wire logic       inByteValid,
	input  wire logic [7:0] inByte,
	output logic            stealGrant,
	output logic            hostReady,
	output logic [7:0]      storeCount
);
	logic [7:0] mem [0:63];
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stealGrant <= 1'b0;
			hostReady  <= 1'b0;
		end else begin
			stealGrant <= stealRequest && !stall;
			hostReady  <= !stall;
		end
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			storeCount <= 8'h00;
		end else if (inByteValid) begin
			mem[storeCount[5:0]] <= inByte;
			storeCount           <= storeCount + 8'h01;
		end
	end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench for the host attachment block.
`timescale 1ns/1ps
`default_nettype none
`include "host_attach_consts.svh"
module testbench;
	logic clock, nrst, commandValid, clockPhaseFive, outByteValid, subsysIrqSet, tapeDataValid, stall;
	host_attach_pkg::cmd_word_type commandWord;
	host_attach_pkg::pbyte_type outByte;
	logic [3:0] unitIrqSet, inboundTags, expectedTag, unitIrqPending;
	logic [7:0] tapeData, inByte, storeCount;
	logic tapeDataReady, stealGrant, hostReady, stealRequest, inByteValid, completionLatch, irqEnable;
	logic subsysIrqPending, processorCheck, channelOutputParityFlag, invalidCommandFlag, ioCheck, hostIrq;
	int n_fail = 0;
	int checked = 0;
	host_attachment_io_control dut (.clock(clock), .nrst(nrst), .commandValid(commandValid),
		.commandWord(commandWord), .clockPhaseFive(clockPhaseFive), .outByteValid(outByteValid),
		.outByte(outByte), .unitIrqSet(unitIrqSet), .subsysIrqSet(subsysIrqSet),
		.subsysSenseByte(8'h5A), .addressRegByte(8'hC3), .hardwareSenseByte(8'h96), .opEndStatus(8'h3C),
		.inboundTags(inboundTags), .expectedTag(expectedTag), .tapeDataValid(tapeDataValid),
		.tapeData(tapeData), .tapeDataReady(tapeDataReady), .stealGrant(stealGrant), .hostReady(hostReady),
		.stealRequest(stealRequest), .inByteValid(inByteValid), .inByte(inByte),
		.completionLatch(completionLatch), .irqEnable(irqEnable), .unitIrqPending(unitIrqPending),
		.subsysIrqPending(subsysIrqPending), .processorCheck(processorCheck),
		.channelOutputParityFlag(channelOutputParityFlag), .invalidCommandFlag(invalidCommandFlag),
		.ioCheck(ioCheck), .hostIrq(hostIrq));
	host_channel_model host (.clock(clock), .nrst(nrst), .stall(stall), .stealRequest(stealRequest),
		.inByteValid(inByteValid), .inByte(inByte), .stealGrant(stealGrant), .hostReady(hostReady),
		.storeCount(storeCount));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic summarize();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic checkVal(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic timeout(input int i, input int lim);
		if (i >= lim) begin
			n_fail++;
			$display("CHECK FAILED wait expected done seen timeout");
			summarize();
		end
	endtask
	task automatic sendCmd(input host_attach_pkg::cmd_type c, input logic [2:0] f, input logic [7:0] s,
		input logic r);
		@(posedge clock);
		commandWord  <= '{c, f, s, r};
		commandValid <= 1'b1;
		@(posedge clock);
		commandValid <= 1'b0;
	endtask
	task automatic sendByte(input logic [7:0] d, input logic bad);
		@(posedge clock);
		outByte      <= '{d, bad ^ ~(^d)};
		outByteValid <= 1'b1;
		@(posedge clock);
		outByteValid <= 1'b0;
	endtask
	task automatic phase();
		@(posedge clock);
		clockPhaseFive <= 1'b1;
		repeat (5) @(posedge clock);
		clockPhaseFive <= 1'b0;
		repeat (5) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic doLoad(input logic [1:0] pat, input logic [1:0] unit, input logic bad);
		sendCmd(host_attach_pkg::CMD_LOAD, `FUNC_LOAD_CTRL, {3'h0, unit, 3'h0}, 1'b0);
		phase();
		checkVal("completionLatch", 8'h01, {7'h0, completionLatch});
		sendByte({3'h0, pat, 3'h0}, bad);
		phase();
		sendByte({3'h0, ~pat, 3'h0}, 1'b0);
		phase();
	endtask
	task automatic loadScenario();
		@(posedge clock);
		unitIrqSet   <= 4'hF;
		subsysIrqSet <= 1'b1;
		@(posedge clock);
		unitIrqSet   <= 4'h0;
		subsysIrqSet <= 1'b0;
		doLoad(`PAT_ENABLE, 2'h0, 1'b0);
		checkVal("irqEnable", 8'h01, {7'h0, irqEnable});
		checkVal("hostIrq", 8'h01, {7'h0, hostIrq});
		checkVal("unitIrqPending", 8'h0F, {4'h0, unitIrqPending});
		doLoad(`PAT_CLEAR_UNIT, 2'h2, 1'b0);
		checkVal("unitIrqPending", 8'h0B, {4'h0, unitIrqPending});
		checkVal("subsysIrqPending", 8'h01, {7'h0, subsysIrqPending});
		doLoad(`PAT_CLEAR_SUBSYS, 2'h0, 1'b0);
		checkVal("subsysIrqPending", 8'h00, {7'h0, subsysIrqPending});
		doLoad(`PAT_DISABLE, 2'h0, 1'b0);
		checkVal("irqEnable", 8'h00, {7'h0, irqEnable});
		checkVal("hostIrq", 8'h00, {7'h0, hostIrq});
		doLoad(`PAT_ENABLE, 2'h0, 1'b1);
		checkVal("irqEnable", 8'h00, {7'h0, irqEnable});
		checkVal("parity flags", 8'h03, {6'h0, processorCheck, channelOutputParityFlag});
		sendCmd(host_attach_pkg::CMD_BAD, 3'h0, 8'h00, 1'b0);
		repeat (3) @(posedge clock);
		@(negedge clock);
		checkVal("invalid flags", 8'h03, {6'h0, processorCheck, invalidCommandFlag});
	endtask
	task automatic senseScenario(input host_attach_pkg::cmd_type c, input logic [1:0] sel,
		input logic [7:0] exp0, input logic [7:0] exp1, input logic both);
		logic [7:0] base;
		int i;
		base = storeCount;
		stall <= 1'b1;
		sendCmd(c, 3'h0, {6'h0, sel}, 1'b0);
		repeat (6) @(posedge clock);
		checkVal("stalled count", base, storeCount);
		stall <= 1'b0;
		for (i = 0; i < 200 && storeCount !== base + 8'h02; i++) @(posedge clock);
		timeout(i, 200);
		@(negedge clock);
		checkVal("sense byte 0", exp0, host.mem[base[5:0]]);
		if (both) checkVal("sense byte 1", exp1, host.mem[base[5:0] + 6'h1]);
	endtask
	task automatic tagScenario();
		int i;
		@(posedge clock);
		inboundTags <= 4'b0011;
		@(posedge clock);
		inboundTags <= 4'b0000;
		for (i = 0; i < 50 && ioCheck !== 1'b1; i++) @(posedge clock);
		timeout(i, 50);
		checkVal("ioCheck", 8'h01, {7'h0, ioCheck});
		sendCmd(host_attach_pkg::CMD_OPEND, 3'h0, 8'h00, 1'b0);
		repeat (6) @(posedge clock);
		@(negedge clock);
		checkVal("ioCheck cleared", 8'h00, {7'h0, ioCheck});
		@(posedge clock);
		expectedTag <= 4'b0001;
		inboundTags <= 4'b0010;
		@(posedge clock);
		expectedTag <= 4'b0000;
		inboundTags <= 4'b0000;
		@(negedge clock);
		checkVal("ioCheck wrong tag", 8'h01, {7'h0, ioCheck});
	endtask
	task automatic readScenario();
		logic [7:0] base;
		logic acc;
		int i, k;
		base = storeCount;
		k = 0;
		stall <= 1'b1;
		sendCmd(host_attach_pkg::CMD_START, 3'h0, 8'hFF, 1'b1);
		tapeDataValid <= 1'b1;
		tapeData      <= 8'hA0;
		for (i = 0; i < 400 && k < 6; i++) begin
			@(negedge clock);
			acc = tapeDataValid && tapeDataReady;
			if (i == 20) checkVal("buffered", 8'h02, k[7:0]);
			@(posedge clock);
			if (i == 20) stall <= 1'b0;
			if (acc) begin
				k++;
				tapeData <= 8'hA0 + k[7:0];
				if (k == 6) tapeDataValid <= 1'b0;
			end
		end
		for (i = 0; i < 300 && storeCount !== base + 8'h06; i++) @(posedge clock);
		timeout(i, 300);
		for (k = 0; k < 6; k++) checkVal("read byte", 8'hA0 + k[7:0], host.mem[base[5:0] + k[5:0]]);
	endtask
	initial begin
		{commandValid, clockPhaseFive, outByteValid, subsysIrqSet, tapeDataValid, stall} = '0;
		commandWord = '0;
		outByte     = '0;
		unitIrqSet  = 4'h0;
		inboundTags = 4'h0;
		expectedTag = 4'h0;
		tapeData    = 8'h00;
		nrst        = 1'b0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		checkVal("reset state", 8'h00, {2'h0, subsysIrqPending, irqEnable, unitIrqPending});
		loadScenario();
		senseScenario(host_attach_pkg::CMD_SENSE, `SRC_SUBSYS, 8'h5A, 8'h5A, 1'b1);
		senseScenario(host_attach_pkg::CMD_SENSE, `SRC_ADDRESS, 8'hC3, 8'hC3, 1'b1);
		senseScenario(host_attach_pkg::CMD_SENSE, `SRC_ATTACH, 8'h2C, 8'h2C, 1'b1);
		senseScenario(host_attach_pkg::CMD_SENSE, `SRC_HARDWARE, 8'h96, 8'h96, 1'b1);
		senseScenario(host_attach_pkg::CMD_OPEND, 2'h0, `ZERO_BYTE, 8'h3C, 1'b1);
		tagScenario();
		readScenario();
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clock);
		timeout(1, 1);
	end
endmodule
`default_nettype wire
